/* ldo_pkg.sv */
// constants, field layouts and carrier types of the logical device option registers
// Contract
// [R1] Each drive option register holds a two-bit drive type select in bits one and zero.
// [R2] Each drive option register holds a two-bit rate table select in bits four and three.
// [R3] Bit six of a drive option register at zero applies precompensation, at one applies none.
// [R4] Bits two, five and seven of each drive option register read as zero and ignore writes.
// [R5] The second drive option register at index f5 matches the first in layout and default.
// [R6] Floppy index f3 is reserved, always reads zero and ignores writes.
// [R7] The parallel mode register keeps the port mode in bits two to zero and resets to 3c.
// [R8] With timeout clear select at zero the timeout flag clears only on a written one.
// [R9] With timeout clear select at one the timeout flag clears at the end of a status read.
// [R10] The second parallel mode register resets to zero and keeps only the clear select bit.
// [R11] Serial mode bit zero at one enables legacy MIDI support, default off.
// [R12] Serial mode bit one at one enables the high speed option, default off.
// [R13] Serial mode bit seven at one makes both channels drive one common request.
// [R14] Software assigns a line to one channel, none to the other, then sets the share bit.
// [R15] With the share bit set both request lines assert when either channel interrupts.
// [R16] Reserved bits six to two of the serial mode register read as zero.
package ldo_pkg;

	// ****************************************
	// address map
	// ****************************************
	localparam int          ADDR_W        = 12;
	localparam logic [1:0]  PAGE_FLOPPY   = 2'h0;
	localparam logic [1:0]  PAGE_PARALLEL = 2'h1;
	localparam logic [1:0]  PAGE_SERIAL   = 2'h2;
	localparam logic [1:0]  PAGE_IRQ      = 2'h3;
	localparam logic [7:0]  IDX_RSVD_F3   = 8'hf3;
	localparam logic [7:0]  IDX_DRIVE0    = 8'hf4;
	localparam logic [7:0]  IDX_DRIVE1    = 8'hf5;
	localparam logic [7:0]  IDX_PAR_MODE  = 8'hf0;
	localparam logic [7:0]  IDX_PAR_MODE2 = 8'hf1;
	localparam logic [7:0]  IDX_SER_MODE  = 8'hf0;
	localparam logic [7:0]  IDX_IRQ_STAT  = 8'h00;
	localparam logic [7:0]  IDX_IRQ_MASK  = 8'h01;
	localparam logic [7:0]  IDX_FLAG_STAT = 8'h02;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0]  RST_DRIVE     = 8'h00;
	localparam logic [7:0]  RST_PAR_MODE  = 8'h3c;
	localparam logic [7:0]  RST_PAR_MODE2 = 8'h00;
	localparam logic [7:0]  RST_SER_MODE  = 8'h00;
	localparam logic [2:0]  RST_IRQ       = 3'h0;

	// ****************************************
	// field positions
	// ****************************************
	localparam int          DRV_TYPE_LSB  = 0;
	localparam int          DRV_RATE_LSB  = 3;
	localparam int          DRV_PCOMP_BIT = 6;
	localparam int          PAR_TSEL_BIT  = 4;
	localparam int          SER_MIDI_BIT  = 0;
	localparam int          SER_HS_BIT    = 1;
	localparam int          SER_SHARE_BIT = 7;
	localparam int          EV_TIMEOUT    = 0;
	localparam int          EV_UART1      = 1;
	localparam int          EV_UART2      = 2;
	localparam int          EV_W          = 3;

	// ****************************************
	// carrier types
	// ****************************************
	typedef struct packed {
		logic       precomp_off;
		logic [1:0] rate_table_sel;
		logic [1:0] drive_type_sel;
	} ldo_drive_opt_type;

	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} ldo_apb_req_type;

endpackage : ldo_pkg

/* ldo_drive_opt.sv */
// one floppy drive option register
`timescale 1ns/10ps
`default_nettype none
module ldo_drive_opt import ldo_pkg::*; (
	input  wire logic              clk_in,
	input  wire logic              srst_in,
	input  wire logic              ce_in,
	input  wire logic              wr_en_in,
	input  wire logic [7:0]        wdata_in,
	output var  ldo_drive_opt_type opt_out,
	output var  logic [7:0]        rdata_out
);

	ldo_drive_opt_type opt_r;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			opt_r <= ldo_drive_opt_type'(RST_DRIVE[$bits(ldo_drive_opt_type)-1:0]);
		end else if (ce_in && wr_en_in) begin
			opt_r.drive_type_sel <= wdata_in[DRV_TYPE_LSB +: 2]; // [R1]
			opt_r.rate_table_sel <= wdata_in[DRV_RATE_LSB +: 2]; // [R2]
			opt_r.precomp_off    <= wdata_in[DRV_PCOMP_BIT];     // [R3]
		end
	end

	// unused bits stay zero on read
	always_comb begin
		rdata_out                     = 8'h00; // [R4]
		rdata_out[DRV_TYPE_LSB +: 2]  = opt_r.drive_type_sel;
		rdata_out[DRV_RATE_LSB +: 2]  = opt_r.rate_table_sel;
		rdata_out[DRV_PCOMP_BIT]      = opt_r.precomp_off;
	end

	assign opt_out = opt_r;

endmodule : ldo_drive_opt
`default_nettype wire

/* ldo_regs.sv */
// option register bank with apb slave, timeout flag and serial interrupt sharing
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module ldo_regs import ldo_pkg::*; (
	input  wire logic              CLK_IN,
	input  wire logic              SRST_IN,
	input  wire logic              CE_IN,
	input  wire logic              PSEL_IN,
	input  wire logic              PENABLE_IN,
	input  wire logic              PWRITE_IN,
	input  wire logic [ADDR_W-1:0] PADDR_IN,
	input  wire logic [31:0]       PWDATA_IN,
	output var  logic [31:0]       PRDATA_OUT,
	output var  logic              PREADY_OUT,
	output var  logic              PSLVERR_OUT,
	input  wire logic              PORT_TIMEOUT_SET_IN,
	input  wire logic              TIMEOUT_WR1_IN,
	input  wire logic              STATUS_RD_IN,
	input  wire logic              UART1_IRQ_IN,
	input  wire logic              UART2_IRQ_IN,
	output var  ldo_drive_opt_type DRIVE_ZERO_OUT,
	output var  ldo_drive_opt_type DRIVE_ONE_OUT,
	output var  logic [2:0]        PAR_MODE_OUT,
	output var  logic              PORT_TIMEOUT_FLAG_OUT,
	output var  logic              MIDI_EN_OUT,
	output var  logic              HIGH_SPEED_EN_OUT,
	output var  logic              SER1_IRQ_OUT,
	output var  logic              SER2_IRQ_OUT,
	output var  logic              IRQ_OUT
);

	// ****************************************
	// declarations
	// ****************************************
	ldo_apb_req_type   req;
	logic [1:0]        page;
	logic [7:0]        idx;
	logic              aligned;
	logic              access;
	logic              commit;
	logic              wr_commit;
	logic              hit;
	logic [7:0]        rdata_nxt;
	logic [7:0]        drv0_rdata;
	logic [7:0]        drv1_rdata;
	logic              wr_drv0;
	logic              wr_drv1;
	logic              wr_par;
	logic              wr_par2;
	logic              wr_ser;
	logic              wr_stat;
	logic              wr_mask;
	logic              pready_r;
	logic [31:0]       prdata_r;
	logic              pslverr_r;
	logic [7:0]        par_mode_r;
	logic              tmo_sel_r;
	logic              midi_r;
	logic              hs_r;
	logic              share_r;
	logic              flag_r;
	logic              flag_nxt;
	logic              rd_s1_r;
	logic              rd_s2_r;
	logic              rd_s3_r;
	logic              rd_lvl_r;
	logic              rd_trail;
	logic              u1_d_r;
	logic              u2_d_r;
	logic [EV_W-1:0]   ev;
	logic [EV_W-1:0]   stat_r;
	logic [EV_W-1:0]   mask_r;
	logic              ser1_irq_r;
	logic              ser2_irq_r;
	logic              irq_r;

	// ****************************************
	// apb decode
	// ****************************************
	assign req.psel    = PSEL_IN;
	assign req.penable = PENABLE_IN;
	assign req.pwrite  = PWRITE_IN;
	assign req.paddr   = PADDR_IN;
	assign req.pwdata  = PWDATA_IN;

	assign page      = req.paddr[ADDR_W-1 -: 2];
	assign idx       = req.paddr[ADDR_W-3 -: 8];
	assign aligned   = (req.paddr[1:0] == 2'h0);
	assign access    = req.psel && req.penable;
	assign commit    = access && pready_r && CE_IN;
	assign wr_commit = commit && req.pwrite && hit;

	always_comb begin
		hit = 1'b0;
		if (aligned) begin
			unique case (page)
				PAGE_FLOPPY:   hit = (idx == IDX_RSVD_F3) || (idx == IDX_DRIVE0) ||
				                     (idx == IDX_DRIVE1);
				PAGE_PARALLEL: hit = (idx == IDX_PAR_MODE) || (idx == IDX_PAR_MODE2);
				PAGE_SERIAL:   hit = (idx == IDX_SER_MODE);
				PAGE_IRQ:      hit = (idx == IDX_IRQ_STAT) || (idx == IDX_IRQ_MASK) ||
				                     (idx == IDX_FLAG_STAT);
			endcase
		end
	end

	assign wr_drv0 = wr_commit && (page == PAGE_FLOPPY) && (idx == IDX_DRIVE0);
	assign wr_drv1 = wr_commit && (page == PAGE_FLOPPY) && (idx == IDX_DRIVE1); // [R5]
	assign wr_par  = wr_commit && (page == PAGE_PARALLEL) && (idx == IDX_PAR_MODE);
	assign wr_par2 = wr_commit && (page == PAGE_PARALLEL) && (idx == IDX_PAR_MODE2);
	assign wr_ser  = wr_commit && (page == PAGE_SERIAL) && (idx == IDX_SER_MODE);
	assign wr_stat = wr_commit && (page == PAGE_IRQ) && (idx == IDX_IRQ_STAT);
	assign wr_mask = wr_commit && (page == PAGE_IRQ) && (idx == IDX_IRQ_MASK);

	// ****************************************
	// read mux
	// ****************************************
	always_comb begin
		rdata_nxt = 8'h00;
		if (hit) begin
			unique case (page)
				PAGE_FLOPPY: begin
					if (idx == IDX_DRIVE0) begin
						rdata_nxt = drv0_rdata;
					end else if (idx == IDX_DRIVE1) begin
						rdata_nxt = drv1_rdata;
					end else begin
						rdata_nxt = 8'h00; // [R6]
					end
				end
				PAGE_PARALLEL: begin
					if (idx == IDX_PAR_MODE) begin
						rdata_nxt = par_mode_r;
					end else begin
						rdata_nxt[PAR_TSEL_BIT] = tmo_sel_r; // [R10]
					end
				end
				PAGE_SERIAL: begin
					rdata_nxt[SER_MIDI_BIT]  = midi_r; // [R16]
					rdata_nxt[SER_HS_BIT]    = hs_r;
					rdata_nxt[SER_SHARE_BIT] = share_r;
				end
				PAGE_IRQ: begin
					if (idx == IDX_IRQ_STAT) begin
						rdata_nxt[EV_W-1:0] = stat_r;
					end else if (idx == IDX_IRQ_MASK) begin
						rdata_nxt[EV_W-1:0] = mask_r;
					end else begin
						rdata_nxt[0] = flag_r;
					end
				end
			endcase
		end
	end

	// ****************************************
	// apb answer, one wait state
	// ****************************************
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (CE_IN) begin
			pready_r  <= access && !pready_r;
			pslverr_r <= access && !pready_r && !hit;
			if (access && !pready_r && !req.pwrite) begin
				prdata_r <= {24'h00_0000, rdata_nxt};
			end else begin
				prdata_r <= 32'h0000_0000;
			end
		end
	end

	// ****************************************
	// floppy drive options
	// ****************************************
	ldo_drive_opt u_drive0 (
		.clk_in    (CLK_IN),
		.srst_in   (SRST_IN),
		.ce_in     (CE_IN),
		.wr_en_in  (wr_drv0),
		.wdata_in  (req.pwdata[7:0]),
		.opt_out   (DRIVE_ZERO_OUT),
		.rdata_out (drv0_rdata)
	);

	ldo_drive_opt u_drive1 (
		.clk_in    (CLK_IN),
		.srst_in   (SRST_IN),
		.ce_in     (CE_IN),
		.wr_en_in  (wr_drv1),
		.wdata_in  (req.pwdata[7:0]),
		.opt_out   (DRIVE_ONE_OUT),
		.rdata_out (drv1_rdata)
	);

	// ****************************************
	// parallel port mode
	// ****************************************
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			par_mode_r <= RST_PAR_MODE; // [R7]
			tmo_sel_r  <= RST_PAR_MODE2[PAR_TSEL_BIT]; // [R10]
		end else if (CE_IN) begin
			if (wr_par) begin
				par_mode_r <= req.pwdata[7:0];
			end
			if (wr_par2) begin
				tmo_sel_r <= req.pwdata[PAR_TSEL_BIT];
			end
		end
	end

	// status read strobe from the port pin side
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			rd_s1_r  <= 1'b0;
			rd_s2_r  <= 1'b0;
			rd_s3_r  <= 1'b0;
			rd_lvl_r <= 1'b0;
		end else if (CE_IN) begin
			rd_s1_r <= STATUS_RD_IN;
			rd_s2_r <= rd_s1_r;
			rd_s3_r <= rd_s2_r;
			if (rd_s2_r == rd_s3_r) begin
				rd_lvl_r <= rd_s3_r;
			end
		end
	end

	assign rd_trail = rd_lvl_r && !rd_s2_r && !rd_s3_r;

	// set beats either clear
	always_comb begin
		flag_nxt = flag_r;
		if (!tmo_sel_r && TIMEOUT_WR1_IN) begin
			flag_nxt = 1'b0; // [R8]
		end
		if (tmo_sel_r && rd_trail) begin
			flag_nxt = 1'b0; // [R9]
		end
		if (PORT_TIMEOUT_SET_IN) begin
			flag_nxt = 1'b1;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			flag_r <= 1'b0;
		end else if (CE_IN) begin
			flag_r <= flag_nxt;
		end
	end

	// ****************************************
	// first serial port mode
	// ****************************************
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			midi_r  <= RST_SER_MODE[SER_MIDI_BIT];
			hs_r    <= RST_SER_MODE[SER_HS_BIT];
			share_r <= RST_SER_MODE[SER_SHARE_BIT];
		end else if (CE_IN && wr_ser) begin
			midi_r  <= req.pwdata[SER_MIDI_BIT]; // [R11]
			hs_r    <= req.pwdata[SER_HS_BIT]; // [R12]
			share_r <= req.pwdata[SER_SHARE_BIT]; // [R13]
		end
	end

	// shared mode drives both lines, so software leaves one unrouted
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			ser1_irq_r <= 1'b0;
			ser2_irq_r <= 1'b0;
		end else if (CE_IN) begin
			ser1_irq_r <= UART1_IRQ_IN || (share_r && UART2_IRQ_IN); // [R13] [R15]
			ser2_irq_r <= UART2_IRQ_IN || (share_r && UART1_IRQ_IN); // [R13] [R15]
		end
	end

	// ****************************************
	// interrupt status and mask
	// ****************************************
	assign ev[EV_TIMEOUT] = PORT_TIMEOUT_SET_IN && !flag_r;
	assign ev[EV_UART1]   = UART1_IRQ_IN && !u1_d_r;
	assign ev[EV_UART2]   = UART2_IRQ_IN && !u2_d_r;

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			u1_d_r <= 1'b0;
			u2_d_r <= 1'b0;
			stat_r <= RST_IRQ;
			mask_r <= RST_IRQ;
			irq_r  <= 1'b0;
		end else if (CE_IN) begin
			u1_d_r <= UART1_IRQ_IN;
			u2_d_r <= UART2_IRQ_IN;
			if (wr_stat) begin
				stat_r <= (stat_r & ~req.pwdata[EV_W-1:0]) | ev;
			end else begin
				stat_r <= stat_r | ev;
			end
			if (wr_mask) begin
				mask_r <= req.pwdata[EV_W-1:0];
			end
			irq_r <= |(stat_r & mask_r);
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign PRDATA_OUT            = prdata_r;
	assign PREADY_OUT            = pready_r;
	assign PSLVERR_OUT           = pslverr_r;
	assign PAR_MODE_OUT          = par_mode_r[2:0]; // [R7]
	assign PORT_TIMEOUT_FLAG_OUT = flag_r;
	assign MIDI_EN_OUT           = midi_r;
	assign HIGH_SPEED_EN_OUT     = hs_r;
	assign SER1_IRQ_OUT          = ser1_irq_r;
	assign SER2_IRQ_OUT          = ser2_irq_r;
	assign IRQ_OUT               = irq_r;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (SRST_IN);

	sequence s_wr_drv0;
		wr_drv0;
	endsequence

	sequence s_rd_commit(logic [1:0] p, logic [7:0] i);
		commit && !req.pwrite && (page == p) && (idx == i) && aligned;
	endsequence

	AST_DRV_TYPE: assert property (s_wr_drv0 |=> // [R1]
		DRIVE_ZERO_OUT.drive_type_sel == $past(req.pwdata[1:0]))
		else $error("drive type select not stored");

	AST_DRV_RATE: assert property (wr_drv1 |=> // [R2]
		DRIVE_ONE_OUT.rate_table_sel == $past(req.pwdata[4:3]))
		else $error("rate table select not stored");

	AST_DRV_PCOMP: assert property (wr_drv0 |=> // [R3]
		DRIVE_ZERO_OUT.precomp_off == $past(req.pwdata[6]))
		else $error("precompensation bit not stored");

	AST_DRV_RSVD: assert property (s_rd_commit(PAGE_FLOPPY, IDX_DRIVE1) |-> // [R4]
		(PRDATA_OUT[7] == 1'b0) && (PRDATA_OUT[5] == 1'b0) && (PRDATA_OUT[2] == 1'b0))
		else $error("drive option reserved bit read nonzero");

	AST_F3_ZERO: assert property (s_rd_commit(PAGE_FLOPPY, IDX_RSVD_F3) |-> // [R6]
		PRDATA_OUT == 32'h0000_0000)
		else $error("reserved index read nonzero");

	AST_PAR_RESET: assert property (@(posedge CLK_IN) disable iff (1'b0) // [R7]
		$past(SRST_IN) |-> (par_mode_r == RST_PAR_MODE) && !tmo_sel_r)
		else $error("parallel mode reset value wrong");

	sequence s_clear_by_write;
		CE_IN && !tmo_sel_r && TIMEOUT_WR1_IN && !PORT_TIMEOUT_SET_IN;
	endsequence

	sequence s_clear_by_read;
		CE_IN && tmo_sel_r && rd_trail && !PORT_TIMEOUT_SET_IN;
	endsequence

	AST_TMO_WR_CLR: assert property (s_clear_by_write |=> !PORT_TIMEOUT_FLAG_OUT) // [R8]
		else $error("timeout flag not cleared by written one");

	AST_TMO_RD_CLR: assert property (s_clear_by_read |=> !PORT_TIMEOUT_FLAG_OUT) // [R9]
		else $error("timeout flag not cleared after status read");

	AST_TMO_HOLD: assert property (CE_IN && tmo_sel_r && flag_r && !rd_trail |=> // [R9]
		PORT_TIMEOUT_FLAG_OUT)
		else $error("timeout flag lost with read clear selected");

	AST_SER_BITS: assert property (wr_ser |=> // [R11]
		(MIDI_EN_OUT == $past(req.pwdata[0])) && (HIGH_SPEED_EN_OUT == $past(req.pwdata[1])))
		else $error("serial mode bits not stored");

	AST_SHARE: assert property (CE_IN && share_r && (UART1_IRQ_IN || UART2_IRQ_IN) |=> // [R15]
		SER1_IRQ_OUT && SER2_IRQ_OUT)
		else $error("shared interrupt not on both lines");

	AST_NOSHARE: assert property (CE_IN && !share_r |=> // [R13]
		SER2_IRQ_OUT == $past(UART2_IRQ_IN))
		else $error("separate interrupt line disturbed");

	AST_SER_RSVD: assert property (s_rd_commit(PAGE_SERIAL, IDX_SER_MODE) |-> // [R16]
		PRDATA_OUT[6:2] == 5'h00)
		else $error("serial mode reserved bits read nonzero");

	// clock enable low stretches the access, so both cycles must run
	sequence s_setup_then_access;
		(CE_IN && PSEL_IN && !PENABLE_IN) ##1 (CE_IN && access) ##1 access;
	endsequence

	AST_PREADY: assert property (s_setup_then_access |-> PREADY_OUT)
		else $error("apb answer late");

endmodule : ldo_regs
`default_nettype wire

/* ldo_regs_tb_top.sv */
// self-checking testbench of the logical device option register bank
`timescale 1ns/10ps
`default_nettype none
module ldo_regs_tb_top import ldo_pkg::*; ;

	// ****************************************
	// signals
	// ****************************************
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic [7:0]  rexp;
		logic        err;
		logic [2:0]  sel;
		logic [7:0]  oexp;
	} ldo_tb_row_type;

	logic              clk   = 1'b0;
	logic              srst  = 1'b1;
	logic              ce    = 1'b1;
	logic              psel  = 1'b0;
	logic              pen   = 1'b0;
	logic              pwr   = 1'b0;
	logic [11:0]       paddr = 12'h000;
	logic [31:0]       pwdata = 32'h0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              to_set = 1'b0;
	logic              to_wr1 = 1'b0;
	logic              st_rd  = 1'b0;
	logic              u1 = 1'b0;
	logic              u2 = 1'b0;
	ldo_drive_opt_type drv0;
	ldo_drive_opt_type drv1;
	logic [2:0]        pmode;
	logic              flag;
	logic              midi;
	logic              hs;
	logic              s1irq;
	logic              s2irq;
	logic              irq;
	int                error_cnt = 0;
	int                n_tests   = 0;
	logic [31:0]       rd;
	logic              er;
	ldo_tb_row_type    rows [11];

	ldo_regs dut (
		.CLK_IN               (clk),
		.SRST_IN              (srst),
		.CE_IN                (ce),
		.PSEL_IN              (psel),
		.PENABLE_IN           (pen),
		.PWRITE_IN            (pwr),
		.PADDR_IN             (paddr),
		.PWDATA_IN            (pwdata),
		.PRDATA_OUT           (prdata),
		.PREADY_OUT           (pready),
		.PSLVERR_OUT          (pslverr),
		.PORT_TIMEOUT_SET_IN  (to_set),
		.TIMEOUT_WR1_IN       (to_wr1),
		.STATUS_RD_IN         (st_rd),
		.UART1_IRQ_IN         (u1),
		.UART2_IRQ_IN         (u2),
		.DRIVE_ZERO_OUT       (drv0),
		.DRIVE_ONE_OUT        (drv1),
		.PAR_MODE_OUT         (pmode),
		.PORT_TIMEOUT_FLAG_OUT(flag),
		.MIDI_EN_OUT          (midi),
		.HIGH_SPEED_EN_OUT    (hs),
		.SER1_IRQ_OUT         (s1irq),
		.SER2_IRQ_OUT         (s2irq),
		.IRQ_OUT              (irq)
	);

	initial begin
		forever #4 clk = ~clk;
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			$display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
			error_cnt++;
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd,
			output logic [31:0] rdat, output logic err);
		int i;
		@(posedge clk);
		psel   <= 1'b1;
		pen    <= 1'b0;
		pwr    <= w;
		paddr  <= a;
		pwdata <= {24'h0, wd};
		@(posedge clk);
		pen <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			error_cnt++;
			test_done();
		end
		rdat = prdata;
		err  = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask : apb

	task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00, rd, er);
		chk(rd, {24'h0, exp});
	endtask : rd_chk

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d, rd, er);
	endtask : wr

	task automatic pulse_set();
		@(posedge clk);
		to_set <= 1'b1;
		@(posedge clk);
		to_set <= 1'b0;
	endtask : pulse_set

	function automatic logic [7:0] obs(input logic [2:0] s);
		case (s)
			3'h1:    return {3'h0, drv0};
			3'h2:    return {3'h0, drv1};
			3'h3:    return {5'h0, pmode};
			3'h4:    return {6'h0, midi, hs};
			default: return 8'h00;
		endcase
	endfunction : obs

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rows[0]  = '{12'h3d0, 8'hff, 8'h5b, 1'b0, 3'h1, 8'h1f};
		rows[1]  = '{12'h3d0, 8'h49, 8'h49, 1'b0, 3'h1, 8'h15};
		rows[2]  = '{12'h3d4, 8'hff, 8'h5b, 1'b0, 3'h2, 8'h1f};
		rows[3]  = '{12'h3d4, 8'h12, 8'h12, 1'b0, 3'h2, 8'h0a};
		rows[4]  = '{12'h3cc, 8'hff, 8'h00, 1'b0, 3'h0, 8'h00};
		rows[5]  = '{12'h7c0, 8'ha5, 8'ha5, 1'b0, 3'h3, 8'h05};
		rows[6]  = '{12'h7c4, 8'hff, 8'h10, 1'b0, 3'h0, 8'h00};
		rows[7]  = '{12'hbc0, 8'hff, 8'h83, 1'b0, 3'h4, 8'h03};
		rows[8]  = '{12'hbc0, 8'h02, 8'h02, 1'b0, 3'h4, 8'h01};
		rows[9]  = '{12'h000, 8'hff, 8'h00, 1'b1, 3'h0, 8'h00};
		rows[10] = '{12'h3d2, 8'hff, 8'h00, 1'b1, 3'h0, 8'h00};
		tick(6);
		srst <= 1'b0;
		// reset values
		chk(pmode, 3'h4);
		rd_chk(12'h3d0, 8'h00);
		rd_chk(12'h3d4, 8'h00);
		rd_chk(12'h7c0, 8'h3c);
		rd_chk(12'h7c4, 8'h00);
		rd_chk(12'hbc0, 8'h00);
		// frozen clock enable ignores a timeout event
		ce <= 1'b0;
		pulse_set();
		tick(3);
		chk(flag, 1'b0);
		ce <= 1'b1;
		foreach (rows[k]) begin
			apb(1'b1, rows[k].addr, rows[k].wdata, rd, er);
			chk(er, rows[k].err);
			tick(2);
			chk(obs(rows[k].sel), rows[k].oexp);
			apb(1'b0, rows[k].addr, 8'h00, rd, er);
			chk(rd, {24'h0, rows[k].rexp});
			chk(er, rows[k].err);
		end
		// reset in mid-run
		@(posedge clk);
		srst <= 1'b1;
		tick(2);
		srst <= 1'b0;
		chk(pmode, 3'h4);
		rd_chk(12'h7c0, 8'h3c);
		rd_chk(12'h3d4, 8'h00);
		rd_chk(12'h7c4, 8'h00);
		// timeout flag, clear on written one
		pulse_set();
		tick(2);
		chk(flag, 1'b1);
		@(posedge clk);
		st_rd <= 1'b1;
		tick(3);
		st_rd <= 1'b0;
		tick(12);
		chk(flag, 1'b1);
		@(posedge clk);
		to_wr1 <= 1'b1;
		@(posedge clk);
		to_wr1 <= 1'b0;
		tick(2);
		chk(flag, 1'b0);
		// timeout flag, clear at the end of a status read
		wr(12'h7c4, 8'h10);
		pulse_set();
		@(posedge clk);
		to_wr1 <= 1'b1;
		@(posedge clk);
		to_wr1 <= 1'b0;
		tick(2);
		chk(flag, 1'b1);
		@(posedge clk);
		st_rd <= 1'b1;
		tick(3);
		chk(flag, 1'b1);
		st_rd <= 1'b0;
		for (int i = 0; i < 12 && flag !== 1'b0; i++) tick(1);
		chk(flag, 1'b0);
		// interrupt status, mask and clear
		wr(12'hc04, 8'h01);
		wr(12'hc00, 8'h07);
		tick(3);
		chk(irq, 1'b0);
		pulse_set();
		tick(4);
		chk(irq, 1'b1);
		rd_chk(12'hc00, 8'h01);
		rd_chk(12'hc08, 8'h01);
		wr(12'hc04, 8'h00);
		tick(3);
		chk(irq, 1'b0);
		wr(12'hc04, 8'h01);
		tick(3);
		chk(irq, 1'b1);
		wr(12'hc00, 8'h01);
		tick(3);
		chk(irq, 1'b0);
		// separate serial requests
		@(posedge clk);
		u1 <= 1'b1;
		tick(3);
		chk({s1irq, s2irq}, 2'b10);
		u1 <= 1'b0;
		u2 <= 1'b1;
		tick(3);
		chk({s1irq, s2irq}, 2'b01);
		u2 <= 1'b0;
		rd_chk(12'hc00, 8'h06);
		// share bit set, either channel request drives both request lines
		wr(12'hbc0, 8'h80);
		@(posedge clk);
		u1 <= 1'b1;
		tick(3);
		chk({s1irq, s2irq}, 2'b11);
		u1 <= 1'b0;
		u2 <= 1'b1;
		tick(3);
		chk({s1irq, s2irq}, 2'b11);
		u2 <= 1'b0;
		tick(3);
		chk({s1irq, s2irq}, 2'b00);
		test_done();
	end

endmodule : ldo_regs_tb_top
`default_nettype wire
